// ===== src/cid_defines.vh
// constants of the core interrupt dispatch block
// assumes an 8-bit register port and a core that pulses instruction cycles
//
// Summary of operation
// - any reset leaves interrupts disabled
// - vector needs global and own enables, peripherals also group
// - every source owns a flag bit
// - flags set regardless of any enable
// - entry flushes, clears global, pushes, vectors 0004h
// - entry copies core context into shadows
// - masked events pend until global set
// - return pops counter, restores context, sets global
// - synchronous event latency three or four cycles
// - asynchronous event latency three to five cycles
`ifndef CID_DEFINES_VH
`define CID_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CID_ADDR_W        3
`define CID_OFS_CTRL      3'h0
`define CID_OFS_EN_A      3'h1
`define CID_OFS_EN_B      3'h2
`define CID_OFS_EN_C      3'h3
`define CID_OFS_FLAG_A    3'h4
`define CID_OFS_FLAG_B    3'h5
`define CID_OFS_FLAG_C    3'h6
`define CID_OFS_IRQ_ST    3'h7

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CID_CTRL_GIE      7
`define CID_CTRL_PGE      6
`define CID_CTRL_EN_LO    3
`define CID_CTRL_FLG_LO   0
`define CID_CTRL_RST      8'h00
`define CID_REG_RST       8'h00

// ----------------------------------------------------------------------
// vector, widths and timing
// ----------------------------------------------------------------------
`define CID_PC_W          15
`define CID_VECTOR        15'h0004
`define CID_CTX_W         32
`define CID_STACK_DEPTH   16
`define CID_SP_W          4
`define CID_ENTRY_CYC     3'h3
`define CID_NUM_CORE      3
`define CID_NUM_PERI      24

`endif

// ===== src/cid_stack_mem.v
// hardware return stack for the dispatch block
// assumes push and pop are never asked in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "cid_defines.vh"
module cid_stack_mem (
  input  wire                  sys_clk_i,
  input  wire                  arst_n_i,
  input  wire                  push_i,
  input  wire                  pop_i,
  input  wire [`CID_PC_W-1:0]  push_data_i,
  output reg  [`CID_PC_W-1:0]  pop_data_o
);
  reg [`CID_PC_W-1:0] mem [0:`CID_STACK_DEPTH-1];
  reg [`CID_SP_W-1:0] sp_reg;
  // ----------------------------------------------------------------------
  // pointer and read register; overflow wraps like the core stack
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_reg     <= {`CID_SP_W{1'b0}};
      pop_data_o <= {`CID_PC_W{1'b0}};
    end else if (push_i) begin
      sp_reg <= sp_reg + 1'b1;
    end else if (pop_i) begin
      sp_reg     <= sp_reg - 1'b1;
      pop_data_o <= mem[sp_reg - 1'b1];
    end
  end
  always @(posedge sys_clk_i) begin
    if (push_i) begin
      mem[sp_reg] <= push_data_i;
    end
  end
endmodule // cid_stack_mem
`default_nettype wire

// ===== src/cid_dispatch.v
// core interrupt dispatch: flags, enables, entry and return sequencing
// assumes the core pulses instr_cyc_i once per instruction cycle and
// presents return_from_irq_instr as a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
`include "cid_defines.vh"
module cid_dispatch (
  input  wire                   sys_clk_i,
  input  wire                   arst_n_i,
  input  wire [`CID_ADDR_W-1:0] reg_addr_i,
  input  wire [7:0]             reg_wdata_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  output reg  [7:0]             reg_rdata_o,
  input  wire                   instr_cyc_i,
  input  wire [`CID_NUM_CORE-1:0] core_evt_sync_i,
  input  wire [`CID_NUM_PERI-1:0] peri_evt_sync_i,
  input  wire [`CID_NUM_CORE-1:0] core_evt_pin_i,
  input  wire                   return_from_irq_instr_i,
  input  wire [`CID_PC_W-1:0]   program_counter_i,
  input  wire [`CID_CTX_W-1:0]  core_ctx_i,
  output reg                    flush_prefetch_o,
  output reg                    pc_load_o,
  output reg  [`CID_PC_W-1:0]   pc_load_val_o,
  output reg                    ctx_restore_o,
  output reg  [`CID_CTX_W-1:0]  shadow_ctx_o,
  output reg                    irq_req_o,
  output reg                    in_service_o,
  output reg                    global_irq_enable_o
);
  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  localparam ST_RUN   = 2'b00;
  localparam ST_ENTRY = 2'b01;
  localparam ST_RET   = 2'b10;

  reg  [7:0]  core_irq_control_reg;
  reg  [7:0]  periph_enable_reg_a;
  reg  [7:0]  periph_enable_reg_b;
  reg  [7:0]  periph_enable_reg_c;
  reg  [7:0]  periph_flag_reg_a;
  reg  [7:0]  periph_flag_reg_b;
  reg  [7:0]  periph_flag_reg_c;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [2:0]  lat_cnt_reg;
  reg  [`CID_NUM_CORE-1:0] pin_s1_reg;
  reg  [`CID_NUM_CORE-1:0] pin_s2_reg;
  reg  [`CID_NUM_CORE-1:0] pin_s3_reg;
  reg  [`CID_NUM_CORE-1:0] pin_lvl_reg;
  wire [`CID_NUM_CORE-1:0] pin_rise;
  wire [`CID_NUM_CORE-1:0] core_evt;
  wire [`CID_NUM_PERI-1:0] peri_en;
  wire [`CID_NUM_PERI-1:0] peri_flag;
  wire        global_irq_enable;
  wire        pge;
  wire        pend;
  wire        take;
  wire        stk_push;
  wire        stk_pop;
  wire [`CID_PC_W-1:0] stk_data;

  // write-enable decode, used for every register
  function wr_hit;
    input [`CID_ADDR_W-1:0] a;
    input [`CID_ADDR_W-1:0] ofs;
    input                   we;
    begin
      wr_hit = we && (a == ofs);
    end
  endfunction

  // ----------------------------------------------------------------------
  // asynchronous event pins: three flops, level accepted when s2 == s3
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_reg  <= {`CID_NUM_CORE{1'b0}};
      pin_s2_reg  <= {`CID_NUM_CORE{1'b0}};
      pin_s3_reg  <= {`CID_NUM_CORE{1'b0}};
      pin_lvl_reg <= {`CID_NUM_CORE{1'b0}};
    end else begin
      pin_s1_reg <= core_evt_pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_lvl_reg <= (pin_s2_reg & pin_s3_reg)
                   | (pin_lvl_reg & (pin_s2_reg | pin_s3_reg));
    end
  end
  // sync delay is what stretches async latency to at most five cycles
  assign pin_rise = (pin_s2_reg & pin_s3_reg) & ~pin_lvl_reg;
  assign core_evt = core_evt_sync_i | pin_rise;

  // ----------------------------------------------------------------------
  // gating
  // ----------------------------------------------------------------------
  assign global_irq_enable = core_irq_control_reg[`CID_CTRL_GIE];
  assign pge = core_irq_control_reg[`CID_CTRL_PGE];
  assign peri_en   = {periph_enable_reg_c, periph_enable_reg_b,
                      periph_enable_reg_a};
  assign peri_flag = {periph_flag_reg_c, periph_flag_reg_b,
                      periph_flag_reg_a};
  // core sources need only their own enable; peripherals also the group
  assign pend = (|(core_irq_control_reg[`CID_CTRL_EN_LO+:`CID_NUM_CORE]
                 & core_irq_control_reg[`CID_CTRL_FLG_LO+:`CID_NUM_CORE]))
              | (pge & |(peri_en & peri_flag));
  // a pending source is taken as soon as global is set again
  assign take = global_irq_enable && pend && (state_reg == ST_RUN);

  // ----------------------------------------------------------------------
  // flags and enables; event set beats software clear
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_peri
      always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          periph_flag_reg_a[g] <= 1'b0;
          periph_flag_reg_b[g] <= 1'b0;
          periph_flag_reg_c[g] <= 1'b0;
        end else begin
          if (peri_evt_sync_i[g])
            periph_flag_reg_a[g] <= 1'b1;
          else if (wr_hit(reg_addr_i, `CID_OFS_FLAG_A, reg_wr_i))
            periph_flag_reg_a[g] <= reg_wdata_i[g];
          if (peri_evt_sync_i[g+8])
            periph_flag_reg_b[g] <= 1'b1;
          else if (wr_hit(reg_addr_i, `CID_OFS_FLAG_B, reg_wr_i))
            periph_flag_reg_b[g] <= reg_wdata_i[g];
          if (peri_evt_sync_i[g+16])
            periph_flag_reg_c[g] <= 1'b1;
          else if (wr_hit(reg_addr_i, `CID_OFS_FLAG_C, reg_wr_i))
            periph_flag_reg_c[g] <= reg_wdata_i[g];
        end
      end
    end
  endgenerate

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      periph_enable_reg_a <= `CID_REG_RST;
      periph_enable_reg_b <= `CID_REG_RST;
      periph_enable_reg_c <= `CID_REG_RST;
    end else begin
      if (wr_hit(reg_addr_i, `CID_OFS_EN_A, reg_wr_i))
        periph_enable_reg_a <= reg_wdata_i;
      if (wr_hit(reg_addr_i, `CID_OFS_EN_B, reg_wr_i))
        periph_enable_reg_b <= reg_wdata_i;
      if (wr_hit(reg_addr_i, `CID_OFS_EN_C, reg_wr_i))
        periph_enable_reg_c <= reg_wdata_i;
    end
  end

  // control register: enables and core flags in one byte
  integer i;
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_irq_control_reg <= `CID_CTRL_RST;
    end else begin
      if (wr_hit(reg_addr_i, `CID_OFS_CTRL, reg_wr_i))
        core_irq_control_reg <= reg_wdata_i;
      for (i = 0; i < `CID_NUM_CORE; i = i + 1) begin
        if (core_evt[i])
          core_irq_control_reg[`CID_CTRL_FLG_LO+i] <= 1'b1;
      end
      // hardware overrides global in the take cycle and in ST_RET
      if (take)
        core_irq_control_reg[`CID_CTRL_GIE] <= 1'b0;
      else if (state_reg == ST_RET)
        core_irq_control_reg[`CID_CTRL_GIE] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // entry / return sequencer; entry timed in instruction cycles, return in one clock
  // ----------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (take)
          state_next = ST_ENTRY;
        else if (return_from_irq_instr_i)
          state_next = ST_RET;
      end
      ST_ENTRY: begin
        if (instr_cyc_i && lat_cnt_reg == `CID_ENTRY_CYC - 3'h1)
          state_next = ST_RUN;
      end
      ST_RET: state_next = ST_RUN;
      default: state_next = ST_RUN;
    endcase
  end

  assign stk_push = take;
  assign stk_pop  = (state_reg == ST_RUN) && !take
                    && return_from_irq_instr_i;

  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg           <= ST_RUN;
      lat_cnt_reg         <= 3'h0;
      flush_prefetch_o    <= 1'b0;
      pc_load_o           <= 1'b0;
      pc_load_val_o       <= {`CID_PC_W{1'b0}};
      ctx_restore_o       <= 1'b0;
      shadow_ctx_o        <= {`CID_CTX_W{1'b0}};
      irq_req_o           <= 1'b0;
      in_service_o        <= 1'b0;
      global_irq_enable_o <= 1'b0;
    end else begin
      state_reg           <= state_next;
      flush_prefetch_o    <= take;
      pc_load_o           <= 1'b0;
      ctx_restore_o       <= 1'b0;
      irq_req_o           <= global_irq_enable && pend;
      // mirror the next value of the global bit, so that the pin and the
      // register never disagree for a cycle around entry and return
      if (take)
        global_irq_enable_o <= 1'b0;
      else if (state_reg == ST_RET)
        global_irq_enable_o <= 1'b1;
      else if (wr_hit(reg_addr_i, `CID_OFS_CTRL, reg_wr_i))
        global_irq_enable_o <= reg_wdata_i[`CID_CTRL_GIE];
      else
        global_irq_enable_o <= core_irq_control_reg[`CID_CTRL_GIE];
      if (take) begin
        shadow_ctx_o <= core_ctx_i;
        lat_cnt_reg  <= 3'h0;
        in_service_o <= 1'b1;
      end else if (state_reg == ST_ENTRY && instr_cyc_i) begin
        lat_cnt_reg <= lat_cnt_reg + 3'h1;
        // vector fetch lands three instruction cycles after entry
        if (lat_cnt_reg == `CID_ENTRY_CYC - 3'h1) begin
          pc_load_o     <= 1'b1;
          pc_load_val_o <= `CID_VECTOR;
        end
      end else if (state_reg == ST_RET) begin
        pc_load_o     <= 1'b1;
        pc_load_val_o <= stk_data;
        ctx_restore_o <= 1'b1;
        in_service_o  <= 1'b0;
      end
    end
  end

  cid_stack_mem u_stack (
    .sys_clk_i   (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .push_i      (stk_push),
    .pop_i       (stk_pop),
    .push_data_i (program_counter_i),
    .pop_data_o  (stk_data)
  );

  // ----------------------------------------------------------------------
  // read port; data one cycle after the strobe
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `CID_OFS_CTRL:   reg_rdata_o <= core_irq_control_reg;
        `CID_OFS_EN_A:   reg_rdata_o <= periph_enable_reg_a;
        `CID_OFS_EN_B:   reg_rdata_o <= periph_enable_reg_b;
        `CID_OFS_EN_C:   reg_rdata_o <= periph_enable_reg_c;
        `CID_OFS_FLAG_A: reg_rdata_o <= periph_flag_reg_a;
        `CID_OFS_FLAG_B: reg_rdata_o <= periph_flag_reg_b;
        `CID_OFS_FLAG_C: reg_rdata_o <= periph_flag_reg_c;
        `CID_OFS_IRQ_ST: reg_rdata_o <= {4'h0, in_service_o, pend,
                                         state_reg};
        default:         reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end
endmodule // cid_dispatch
`default_nettype wire

// ===== testbench/cid_dispatch_props.sv
// port assertions of the interrupt dispatch block
// assumes one clock domain and the block's constant header
`timescale 1ns/1ns
`default_nettype none
`include "cid_defines.vh"
module cid_dispatch_props (
  input wire logic                  sys_clk_i,
  input wire logic                  arst_n_i,
  input wire logic                  return_from_irq_instr_i,
  input wire logic                  flush_prefetch_o,
  input wire logic                  pc_load_o,
  input wire logic [`CID_PC_W-1:0]  pc_load_val_o,
  input wire logic                  ctx_restore_o,
  input wire logic [`CID_CTX_W-1:0] shadow_ctx_o,
  input wire logic                  in_service_o,
  input wire logic                  global_irq_enable_o
);
  // ------------------------------------------------------------------
  // reset, entry and return sequencing
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  reset_quiet_a: assert property (
    $rose(arst_n_i) |-> !global_irq_enable_o && !in_service_o)
    else $error("interrupts live after reset");
  entry_gie_a: assert property (
    flush_prefetch_o |-> !global_irq_enable_o)
    else $error("global enable kept on entry");
  entry_vector_a: assert property (
    flush_prefetch_o |-> ##[1:16] (pc_load_o &&
      pc_load_val_o == `CID_VECTOR))
    else $error("vector not loaded in time");
  load_vector_a: assert property (
    pc_load_o && !ctx_restore_o |-> pc_load_val_o == `CID_VECTOR)
    else $error("entry load is not the vector");
  return_gie_a: assert property (
    ctx_restore_o |-> global_irq_enable_o && pc_load_o)
    else $error("return without load or enable");
  return_delay_a: assert property (
    ctx_restore_o |-> $past(return_from_irq_instr_i, 2))
    else $error("restore without return");
  gie_before_a: assert property (
    flush_prefetch_o |->
      $past(global_irq_enable_o, 1) || $past(global_irq_enable_o, 2))
    else $error("entry while globally disabled");
  shadow_entry_a: assert property (
    $changed(shadow_ctx_o) |-> flush_prefetch_o)
    else $error("shadow changed outside entry");
endmodule // cid_dispatch_props

bind cid_dispatch cid_dispatch_props props_u (.sys_clk_i, .arst_n_i,
  .return_from_irq_instr_i, .flush_prefetch_o, .pc_load_o, .pc_load_val_o,
  .ctx_restore_o, .shadow_ctx_o, .in_service_o, .global_irq_enable_o);
`default_nettype wire

// ===== testbench/cid_core_model.sv
// core pipeline model: paces instruction cycles, follows pc loads
// assumes the dispatch block drives pc_load for one cycle
`timescale 1ns/1ns
`default_nettype none
`include "cid_defines.vh"
module cid_core_model (
  input  wire logic                  sys_clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  ret_go_i,
  input  wire logic                  pc_load_i,
  input  wire logic [`CID_PC_W-1:0]  pc_load_val_i,
  output var  logic                  instr_cyc_o,
  output var  logic                  ret_o,
  output var  logic [`CID_PC_W-1:0]  pc_o,
  output wire logic [`CID_CTX_W-1:0] ctx_o
);
  // ------------------------------------------------------------------
  // one instruction every four clocks
  // ------------------------------------------------------------------
  logic [1:0] phase;
  assign ctx_o = {pc_o, 2'h0, pc_o};
  always @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase       <= 2'h0;
      instr_cyc_o <= 1'b0;
      ret_o       <= 1'b0;
      pc_o        <= 15'h0100;
    end else begin
      phase       <= phase + 2'h1;
      instr_cyc_o <= (phase == 2'h3);
      // return issued one clock after the bench asks, with no check for entry
      ret_o       <= ret_go_i;
      if (pc_load_i)
        pc_o <= pc_load_val_i;
      else if (instr_cyc_o)
        pc_o <= pc_o + 15'h0001;
    end
  end
endmodule // cid_core_model
`default_nettype wire

// ===== testbench/core_interrupt_dispatch_tb_top.sv
// self-checking bench of the interrupt dispatch block
// assumes the core model paces instructions and returns on request
`timescale 1ns/1ns
`default_nettype none
`include "cid_defines.vh"
module core_interrupt_dispatch_tb_top;
  logic                     clk, rst_n, wr, rd, ret_go, instr_cyc, ret;
  logic [`CID_ADDR_W-1:0]   addr, k;
  logic [7:0]               wdata, rdata;
  logic [`CID_NUM_CORE-1:0] core_sync, core_pin;
  logic [`CID_NUM_PERI-1:0] peri;
  logic [`CID_PC_W-1:0]     pc, pc_q, saved_pc, load_val;
  logic [`CID_CTX_W-1:0]    ctx, ctx_q, saved_ctx, shadow;
  logic                     flush, pc_load, restore, irq_req, in_svc, global_irq_enable;
  int                       bad_count, n_compared, n_entry, lat;

  always #10 clk = ~clk;

  cid_dispatch dut_u (
    .sys_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .instr_cyc_i(instr_cyc), .core_evt_sync_i(core_sync),
    .peri_evt_sync_i(peri), .core_evt_pin_i(core_pin),
    .return_from_irq_instr_i(ret), .program_counter_i(pc),
    .core_ctx_i(ctx), .flush_prefetch_o(flush), .pc_load_o(pc_load),
    .pc_load_val_o(load_val), .ctx_restore_o(restore),
    .shadow_ctx_o(shadow), .irq_req_o(irq_req), .in_service_o(in_svc),
    .global_irq_enable_o(global_irq_enable));
  cid_core_model core_u (
    .sys_clk_i(clk), .arst_n_i(rst_n), .ret_go_i(ret_go),
    .pc_load_i(pc_load), .pc_load_val_i(load_val), .instr_cyc_o(instr_cyc),
    .ret_o(ret), .pc_o(pc), .ctx_o(ctx));

  // ------------------------------------------------------------------
  // expected push and shadow: core state in the cycle of the take
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    pc_q <= pc;
    ctx_q <= ctx;
    if (flush === 1'b1) begin
      n_entry <= n_entry + 1;
      saved_pc <= pc_q;
      saved_ctx <= ctx_q;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("read data", rdata, e);
  endtask
  task automatic pulse(input logic [2:0] c, input logic [23:0] p);
    @(posedge clk);
    core_sync <= c;
    peri <= p;
    @(posedge clk);
    core_sync <= 3'h0;
    peri <= 24'h00_0000;
  endtask
  // counts instruction cycles until the vector load
  task automatic wait_load;
    int i;
    lat = 0;
    for (i = 0; i < 300 && pc_load !== 1'b1; i++) begin
      @(posedge clk);
      #1 if (instr_cyc === 1'b1) lat++;
    end
    if (pc_load !== 1'b1) begin
      bad_count++;
      summarize;
    end
  endtask
  task automatic do_return;
    int i;
    @(posedge clk);
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    for (i = 0; i < 50 && restore !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (restore !== 1'b1) begin
      bad_count++;
      summarize;
    end
    chk("return pc", load_val, saved_pc);
    chk("return enable", global_irq_enable, 1'b1);
  endtask

  initial begin
    clk = 0; rst_n = 0; wr = 0; rd = 0; ret_go = 0; addr = 0; wdata = 0;
    core_sync = 0; core_pin = 0; peri = 0; n_entry = 0;
    bad_count = 0; n_compared = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`CID_OFS_CTRL, `CID_CTRL_RST);
    chk("enable", global_irq_enable, 1'b0);
    pulse(3'h5, 24'h01_0101);
    rd_reg(`CID_OFS_CTRL, 8'h05);
    for (k = 3'h0; k < 3'h3; k++) rd_reg(`CID_OFS_FLAG_A + k, 8'h01);
    chk("service", in_svc, 1'b0);
    for (k = 3'h0; k < 3'h3; k++) wr_reg(`CID_OFS_FLAG_A + k, 8'h00);
    wr_reg(`CID_OFS_EN_A, 8'h01);
    rd_reg(`CID_OFS_EN_A, 8'h01);
    // global on, group off: a peripheral event only pends
    wr_reg(`CID_OFS_CTRL, 8'h80);
    pulse(3'h0, 24'h00_0001);
    repeat (20) @(posedge clk);
    #1 chk("request", irq_req, 1'b0);
    chk("entries", n_entry, 0);
    wr_reg(`CID_OFS_CTRL, 8'hC0);
    wait_load;
    chk("vector", load_val, `CID_VECTOR);
    chk("take enable", global_irq_enable, 1'b0);
    chk("in service", in_svc, 1'b1);
    chk("shadow", shadow, saved_ctx);
    pulse(3'h0, 24'h00_0001);
    repeat (20) @(posedge clk);
    #1 chk("reentry", n_entry, 1);
    rd_reg(`CID_OFS_FLAG_A, 8'h01);
    wr_reg(`CID_OFS_FLAG_A, 8'h00);
    do_return;
    repeat (20) @(posedge clk);
    #1 chk("repeat", n_entry, 1);
    pulse(3'h0, 24'h00_0001);
    wait_load;
    chk("sync latency", lat >= 3 && lat <= 4, 1'b1);
    wr_reg(`CID_OFS_FLAG_A, 8'h00);
    do_return;
    // core source needs no group enable
    wr_reg(`CID_OFS_CTRL, 8'h88);
    @(posedge clk);
    core_pin <= 3'h1;
    wait_load;
    chk("async latency", lat >= 3 && lat <= 5, 1'b1);
    core_pin <= 3'h0;
    wr_reg(`CID_OFS_CTRL, 8'h08);
    do_return;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`CID_OFS_CTRL, `CID_CTRL_RST);
    rd_reg(`CID_OFS_EN_A, `CID_REG_RST);
    summarize;
  end
endmodule // core_interrupt_dispatch_tb_top
`default_nettype wire
